//--- logic/csc_pkg.sv
// Constants shared by the clock source controller files.
// Assumes a single 250 MHz clock domain and a word-aligned register port.
package csc_pkg;
  localparam int CSC_ADDR_W = 8;
  localparam int CSC_DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] CSC_OFF_TASKS = 8'h00;
  localparam logic [7:0] CSC_OFF_EVENTS = 8'h04;
  localparam logic [7:0] CSC_OFF_LFSRC = 8'h08;
  localparam logic [7:0] CSC_OFF_LFSTAT = 8'h0C;
  localparam logic [7:0] CSC_OFF_HFSTAT = 8'h10;
  // Task bits in the task register
  localparam int CSC_TASK_HF_START = 0;
  localparam int CSC_TASK_HF_STOP = 1;
  localparam int CSC_TASK_LF_START = 2;
  localparam int CSC_TASK_LF_STOP = 3;
  // Event flag bits
  localparam int CSC_EVT_HF = 0;
  localparam int CSC_EVT_LF = 1;
  // Status bits
  localparam int CSC_LFSTAT_SRC = 0;
  localparam int CSC_LFSTAT_RUN = 1;
  localparam int CSC_HFSTAT_XO = 0;
  localparam int CSC_HFSTAT_ON = 1;
  localparam int CSC_HFSTAT_SAVE = 2;
  // Low-frequency source codes
  localparam logic CSC_LF_SRC_RC = 1'b0;
  localparam logic CSC_LF_SRC_XO = 1'b1;
  localparam logic CSC_LFSRC_RESET = CSC_LF_SRC_RC;
  // Divider: 64 source ticks per 1 MHz pulse
  localparam int CSC_DIV_W = 6;
  localparam logic [CSC_DIV_W-1:0] CSC_MASK_32M = 6'h01;
  localparam logic [CSC_DIV_W-1:0] CSC_MASK_16M = 6'h03;
  localparam logic [CSC_DIV_W-1:0] CSC_MASK_1M = 6'h3F;
  localparam logic [CSC_DATA_W-1:0] CSC_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    CSC_HF_OFF = 2'b00,
    CSC_HF_INT = 2'b01,
    CSC_HF_XO = 2'b10
  } csc_hf_state_t;
  typedef enum logic {
    CSC_LFM_FOLLOW = 1'b0,
    CSC_LFM_PARK = 1'b1
  } csc_lfm_state_t;
endpackage

//--- logic/csc_clock_divider.sv
// Divides the selected 64 MHz source ticks into gated clock enables.
// Assumes source ticks are one-cycle pulses synchronous to clock.
`timescale 1ns/1ps
module csc_clock_divider import csc_pkg::*; #(
  parameter int CNT_W = CSC_DIV_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_en,
  input wire logic run,
  input wire logic tick,
  input wire logic cpu_req,
  input wire logic req_1m,
  input wire logic req_16m,
  input wire logic req_32m,
  output logic cpu_en,
  output logic en_1m,
  output logic en_16m,
  output logic en_32m
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_cpu_en, next_en_1m, next_en_16m, next_en_32m;

  // Pulse when all masked counter bits are set
  function automatic logic hits(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] mask);
    hits = (cnt & mask) == mask;
  endfunction

  // Each output only pulses while its own consumer asks for it
  always_comb begin
    next_count = count;
    if (!run) begin
      next_count = '0;
    end else if (tick) begin
      next_count = count + 1'b1;
    end
    next_cpu_en = run & tick & cpu_req;
    next_en_32m = run & tick & req_32m & hits(count, CNT_W'(CSC_MASK_32M));
    next_en_16m = run & tick & req_16m & hits(count, CNT_W'(CSC_MASK_16M));
    next_en_1m = run & tick & req_1m & hits(count, CNT_W'(CSC_MASK_1M));
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      cpu_en <= 1'b0;
      en_1m <= 1'b0;
      en_16m <= 1'b0;
      en_32m <= 1'b0;
    end else if (clock_en) begin
      count <= next_count;
      cpu_en <= next_cpu_en;
      en_1m <= next_en_1m;
      en_16m <= next_en_16m;
      en_32m <= next_en_32m;
    end
  end
endmodule

//--- logic/csc_lf_mux.sv
// Glitch-free two-way mux for the low-frequency clock levels.
// Assumes both source levels are sampled synchronously to clock.
`timescale 1ns/1ps
module csc_lf_mux import csc_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_en,
  input wire logic enable,
  input wire logic target_xo,
  input wire logic rc_level,
  input wire logic xo_level,
  output logic out_clock,
  output logic cur_xo,
  output logic parked
);
  csc_lfm_state_t state, next_state;
  logic next_out, next_cur;
  logic cur_level, new_level;
  logic new_high, next_new_high;

  assign cur_level = cur_xo ? xo_level : rc_level;
  assign new_level = target_xo ? xo_level : rc_level;
  assign parked = state == CSC_LFM_PARK;

  // Park low after old source falls, resume once the new source falls;
  // waiting for a fall, not a low level, keeps the low phase from shrinking
  // (R11) stretch, never glitch
  always_comb begin
    next_state = state;
    next_cur = cur_xo;
    next_out = enable & cur_level;
    next_new_high = 1'b0;
    unique case (state)
      CSC_LFM_FOLLOW: begin
        if (target_xo != cur_xo && !cur_level) begin
          next_state = CSC_LFM_PARK;
          next_out = 1'b0;
        end
      end
      CSC_LFM_PARK: begin
        next_out = 1'b0;
        next_new_high = new_high | new_level;
        if (new_high && !new_level) begin
          next_state = CSC_LFM_FOLLOW;
          next_cur = target_xo;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= CSC_LFM_FOLLOW;
      cur_xo <= CSC_LFSRC_RESET;
      out_clock <= 1'b0;
      new_high <= 1'b0;
    end else if (clock_en) begin
      state <= next_state;
      new_high <= next_new_high;
      cur_xo <= next_cur;
      out_clock <= next_out;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_park_low;
    parked |-> !out_clock;
  endproperty
  a_park_low: assert property (p_park_low) else $error("output high while parked"); // R11

  property p_switch_low;
    $changed(cur_xo) |-> !out_clock && $past(parked);
  endproperty
  a_switch_low: assert property (p_switch_low) else $error("source switched while high"); // R11
endmodule

//--- logic/csc_top.sv
// Clock source controller: high- and low-frequency source control.
// Assumes oscillator ticks, levels and ready flags are synchronous.
// Summary of operation
// (R1) CPU 64 MHz and 1, 16, 32 MHz enables come from chosen source.
// (R2) Only requested clocks run; no request turns the internal source off.
// (R3) Each consumer's request gates its own clock automatically.
// (R4) Internal oscillator feeds requests while crystal is not started.
// (R5) Start task runs the crystal; stop task halts it.
// (R6) Started event when crystal runs and reports stable.
// (R7) System off holds the low-frequency side off.
// (R8) Software selects low-frequency source before the start task.
// (R9) Low-frequency source may change while the clock runs.
// (R10) Old source drives the clock until the new one is ready.
// (R11) Switching never glitches; one pulse may stretch.
// (R12) Running watchdog starts the RC source without a task.
// (R13) Low-frequency started event once selected source runs.
// (R14) First crystal selection keeps RC clock until crystal is stable.
// (R15) Stop task drops only the global request; others keep it.
// (R16) Software stops only after status reports running.
// (R17) Source select resets to the RC oscillator.
// (R18) Modem use requires software to select the crystal source.
// (R19) Tasks are one-cycle writes; events are sticky until cleared.
// (R20) Start beats stop arriving in the same cycle.
`timescale 1ns/1ps
module csc_top import csc_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  input wire logic [CSC_ADDR_W-1:0] reg_addr,
  input wire logic [CSC_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [CSC_DATA_W-1:0] reg_rdata,
  input wire logic cpu_clock_req,
  input wire logic periph_1m_req,
  input wire logic periph_16m_req,
  input wire logic periph_32m_req,
  input wire logic hf_internal_osc_tick,
  input wire logic hf_crystal_osc_tick,
  input wire logic hf_crystal_osc_stable,
  output logic hf_internal_osc_enable,
  output logic hf_crystal_osc_enable,
  output logic hf_power_save,
  output logic high_freq_clock_en,
  output logic periph_clock_1m_en,
  output logic periph_clock_16m_en,
  output logic periph_clock_32m_en,
  input wire logic lf_rc_osc_level,
  input wire logic lf_rc_osc_ready,
  input wire logic lf_crystal_osc_level,
  input wire logic lf_crystal_osc_ready,
  output logic lf_rc_osc_enable,
  output logic lf_crystal_osc_enable,
  output logic low_freq_clock,
  input wire logic watchdog_running,
  input wire logic modem_lf_req,
  input wire logic system_off
);
  logic rst_meta, rst_n;
  logic wr_tasks, wr_events, wr_lfsrc;
  logic hf_start_task, hf_stop_task, lf_start_task, lf_stop_task;
  logic hf_any_req, hf_xo_ok, hf_tick, hf_run;
  csc_hf_state_t hf_state, next_hf_state;
  logic xo_on, next_xo_on, hf_xo_seen, next_hf_xo_seen;
  logic lf_global_req, next_lf_global_req;
  logic lf_source_select, next_lf_source_select;
  logic lf_want_xo, next_lf_want_xo;
  logic lf_need, lf_eff_xo, lf_target_xo, lf_cur_xo, lf_parked, lf_ok;
  logic lf_run, next_lf_run;
  logic hf_started_event, next_hf_started_event;
  logic lf_started_event, next_lf_started_event;
  logic [CSC_DATA_W-1:0] next_rdata;

  // Reset released through two flops; the first is read only by the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Register port decode
  // (R19) one-cycle task strobes
  assign wr_tasks = reg_write && reg_addr == CSC_OFF_TASKS;
  assign wr_events = reg_write && reg_addr == CSC_OFF_EVENTS;
  assign wr_lfsrc = reg_write && reg_addr == CSC_OFF_LFSRC;
  assign hf_start_task = wr_tasks & reg_wdata[CSC_TASK_HF_START];
  assign hf_stop_task = wr_tasks & reg_wdata[CSC_TASK_HF_STOP];
  assign lf_start_task = wr_tasks & reg_wdata[CSC_TASK_LF_START];
  assign lf_stop_task = wr_tasks & reg_wdata[CSC_TASK_LF_STOP];

  // High-frequency request summary
  // (R3) consumers request directly, no software
  assign hf_any_req = cpu_clock_req | periph_1m_req | periph_16m_req | periph_32m_req;
  assign hf_xo_ok = xo_on & hf_crystal_osc_stable;

  // High-frequency source selection
  always_comb begin
    // (R5) (R20) start wins over stop
    next_xo_on = xo_on;
    if (hf_start_task) begin
      next_xo_on = 1'b1;
    end else if (hf_stop_task) begin
      next_xo_on = 1'b0;
    end
    next_hf_xo_seen = hf_xo_ok;
    // (R2) (R4) internal until crystal stable, off with no request
    next_hf_state = hf_state;
    unique case (hf_state)
      CSC_HF_OFF, CSC_HF_INT, CSC_HF_XO: begin
        if (hf_xo_ok) begin
          next_hf_state = CSC_HF_XO;
        end else if (hf_any_req) begin
          next_hf_state = CSC_HF_INT;
        end else begin
          next_hf_state = CSC_HF_OFF;
        end
      end
      default: next_hf_state = CSC_HF_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      xo_on <= 1'b0;
      hf_xo_seen <= 1'b0;
      hf_state <= CSC_HF_OFF;
    end else if (clock_en) begin
      xo_on <= next_xo_on;
      hf_xo_seen <= next_hf_xo_seen;
      hf_state <= next_hf_state;
    end
  end

  // Internal enable follows the selected source; crystal enable follows the start and stop tasks
  assign hf_crystal_osc_enable = xo_on;
  assign hf_internal_osc_enable = hf_state == CSC_HF_INT;
  assign hf_power_save = hf_state == CSC_HF_OFF && !xo_on;

  // (R1) derived clocks from the selected source
  assign hf_tick = hf_state == CSC_HF_XO ? hf_crystal_osc_tick :
                   hf_state == CSC_HF_INT ? hf_internal_osc_tick : 1'b0;
  assign hf_run = hf_any_req && hf_state != CSC_HF_OFF;

  csc_clock_divider u_divider (
    .clock(clock),
    .rst_n(rst_n),
    .clock_en(clock_en),
    .run(hf_run),
    .tick(hf_tick),
    .cpu_req(cpu_clock_req),
    .req_1m(periph_1m_req),
    .req_16m(periph_16m_req),
    .req_32m(periph_32m_req),
    .cpu_en(high_freq_clock_en),
    .en_1m(periph_clock_1m_en),
    .en_16m(periph_clock_16m_en),
    .en_32m(periph_clock_32m_en)
  );

  // Low-frequency demand; software's choice only counts under its request
  // (R7) (R12) (R15) any requester keeps it, system off forces off
  assign lf_need = (lf_global_req | watchdog_running | modem_lf_req) & ~system_off;
  assign lf_eff_xo = lf_global_req & lf_want_xo;

  // (R9) (R10) switch only once the new source is ready
  assign lf_target_xo = (lf_eff_xo & lf_crystal_osc_ready) ? CSC_LF_SRC_XO :
                        (!lf_eff_xo & lf_rc_osc_ready) ? CSC_LF_SRC_RC : lf_cur_xo;
  // (R14) RC stays on while it still drives the output
  assign lf_rc_osc_enable = lf_need & (~lf_eff_xo | ~lf_cur_xo);
  assign lf_crystal_osc_enable = lf_need & (lf_eff_xo | lf_cur_xo);
  assign lf_ok = lf_need && !lf_parked && lf_cur_xo == lf_eff_xo &&
                 (lf_cur_xo ? lf_crystal_osc_ready : lf_rc_osc_ready);

  csc_lf_mux u_lf_mux (
    .clock(clock),
    .rst_n(rst_n),
    .clock_en(clock_en),
    .enable(lf_need),
    .target_xo(lf_target_xo),
    .rc_level(lf_rc_osc_level),
    .xo_level(lf_crystal_osc_level),
    .out_clock(low_freq_clock),
    .cur_xo(lf_cur_xo),
    .parked(lf_parked)
  );

  // Low-frequency control state
  always_comb begin
    // (R15) (R20) stop drops the global request only
    next_lf_global_req = lf_global_req;
    if (lf_start_task) begin
      next_lf_global_req = 1'b1;
    end else if (lf_stop_task) begin
      next_lf_global_req = 1'b0;
    end
    // (R17) software select, taken at start
    next_lf_source_select = wr_lfsrc ? reg_wdata[0] : lf_source_select;
    next_lf_want_xo = lf_start_task ? lf_source_select : lf_want_xo;
    next_lf_run = lf_ok;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lf_global_req <= 1'b0;
      lf_source_select <= CSC_LFSRC_RESET;
      lf_want_xo <= CSC_LFSRC_RESET;
      lf_run <= 1'b0;
    end else if (clock_en) begin
      lf_global_req <= next_lf_global_req;
      lf_source_select <= next_lf_source_select;
      lf_want_xo <= next_lf_want_xo;
      lf_run <= next_lf_run;
    end
  end

  // Sticky events; a set in the clearing cycle is kept
  always_comb begin
    // (R6) (R13) (R19) set beats write-one-to-clear
    next_hf_started_event = hf_started_event;
    next_lf_started_event = lf_started_event;
    if (wr_events && reg_wdata[CSC_EVT_HF]) begin
      next_hf_started_event = 1'b0;
    end
    if (wr_events && reg_wdata[CSC_EVT_LF]) begin
      next_lf_started_event = 1'b0;
    end
    if (hf_xo_ok && !hf_xo_seen) begin
      next_hf_started_event = 1'b1;
    end
    if (lf_ok && !lf_run) begin
      next_lf_started_event = 1'b1;
    end
  end

  // Read data only in the cycle after the read strobe
  always_comb begin
    next_rdata = CSC_ZERO;
    if (reg_read) begin
      unique case (reg_addr)
        CSC_OFF_EVENTS: begin
          next_rdata[CSC_EVT_HF] = hf_started_event;
          next_rdata[CSC_EVT_LF] = lf_started_event;
        end
        CSC_OFF_LFSRC: next_rdata[0] = lf_source_select;
        CSC_OFF_LFSTAT: begin
          next_rdata[CSC_LFSTAT_SRC] = lf_cur_xo;
          next_rdata[CSC_LFSTAT_RUN] = lf_run;
        end
        CSC_OFF_HFSTAT: begin
          next_rdata[CSC_HFSTAT_XO] = hf_state == CSC_HF_XO;
          next_rdata[CSC_HFSTAT_ON] = hf_state != CSC_HF_OFF;
          next_rdata[CSC_HFSTAT_SAVE] = hf_power_save;
        end
        default: next_rdata = CSC_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hf_started_event <= 1'b0;
      lf_started_event <= 1'b0;
      reg_rdata <= CSC_ZERO;
    end else if (clock_en) begin
      hf_started_event <= next_hf_started_event;
      lf_started_event <= next_lf_started_event;
      reg_rdata <= next_rdata;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_hf_go;
    clock_en && hf_start_task;
  endsequence
  sequence s_hf_both;
    s_hf_go ##0 hf_stop_task;
  endsequence

  property p_hf_start;
    s_hf_go |=> hf_crystal_osc_enable;
  endproperty
  a_hf_start: assert property (p_hf_start) else $error("crystal not started"); // R5

  property p_start_wins;
    s_hf_both |=> xo_on [*1] ##0 !hf_power_save;
  endproperty
  a_start_wins: assert property (p_start_wins) else $error("stop beat start"); // R20

  property p_hf_int;
    clock_en && hf_any_req && !hf_xo_ok |=> hf_internal_osc_enable && !hf_power_save;
  endproperty
  a_hf_int: assert property (p_hf_int) else $error("internal source not used"); // R4

  property p_hf_off;
    clock_en && !hf_any_req && !xo_on ##1 !xo_on |-> !hf_internal_osc_enable && hf_power_save;
  endproperty
  a_hf_off: assert property (p_hf_off) else $error("source left on unrequested"); // R2

  property p_hf_event;
    clock_en && hf_xo_ok && !hf_xo_seen |=> hf_started_event;
  endproperty
  a_hf_event: assert property (p_hf_event) else $error("hf started event missing"); // R6

  property p_div_cpu;
    clock_en && hf_run && hf_tick && cpu_clock_req |=> high_freq_clock_en;
  endproperty
  a_div_cpu: assert property (p_div_cpu) else $error("cpu clock enable missing"); // R1

  property p_sys_off;
    system_off && clock_en ##1 system_off |-> !low_freq_clock && !lf_rc_osc_enable;
  endproperty
  a_sys_off: assert property (p_sys_off) else $error("lf side on in system off"); // R7

  property p_lf_keep;
    clock_en && lf_stop_task ##1 (watchdog_running || modem_lf_req) && !system_off |->
      lf_rc_osc_enable || lf_crystal_osc_enable;
  endproperty
  a_lf_keep: assert property (p_lf_keep) else $error("stop killed needed clock"); // R15

  property p_lf_old;
    lf_need && lf_cur_xo != lf_eff_xo |->
      (lf_cur_xo ? lf_crystal_osc_enable : lf_rc_osc_enable);
  endproperty
  a_lf_old: assert property (p_lf_old) else $error("old lf source dropped early"); // R10

  property p_lf_event;
    clock_en && lf_ok && !lf_run |=> lf_started_event && lf_run;
  endproperty
  a_lf_event: assert property (p_lf_event) else $error("lf started event missing"); // R13

  property p_lf_reset;
    $rose(rst_n) |-> lf_source_select == CSC_LF_SRC_RC;
  endproperty
  a_lf_reset: assert property (p_lf_reset) else $error("bad source select reset"); // R17
endmodule

//--- tb/csc_osc_model.sv
// Behavioural oscillators on the far side of the clock source controller.
// Assumes enables come from the controller and are synchronous to clock.
`timescale 1ns/1ps
module csc_osc_model #(
  parameter int XO_START = 40,
  parameter int RC_START = 20,
  parameter int LX_START = 200
) (
  input wire logic clock,
  input wire logic hf_internal_osc_enable,
  input wire logic hf_crystal_osc_enable,
  input wire logic lf_rc_osc_enable,
  input wire logic lf_crystal_osc_enable,
  output logic hf_internal_osc_tick,
  output logic hf_crystal_osc_tick,
  output logic hf_crystal_osc_stable,
  output logic lf_rc_osc_level,
  output logic lf_rc_osc_ready,
  output logic lf_crystal_osc_level,
  output logic lf_crystal_osc_ready
);
  int div = 0;
  int xo_age = 0;
  int rc_age = 0;
  int lx_age = 0;
  // Quiet outputs until the first edge
  initial begin
    {hf_internal_osc_tick, hf_crystal_osc_tick, hf_crystal_osc_stable} = 3'h0;
    {lf_rc_osc_level, lf_rc_osc_ready, lf_crystal_osc_level, lf_crystal_osc_ready} = 4'h0;
  end
  // Stopped oscillators give no ticks and no wave, so stale levels never leak
  always @(posedge clock) begin
    div <= div + 1;
    hf_internal_osc_tick <= hf_internal_osc_enable && (div % 4 == 0);
    hf_crystal_osc_tick <= hf_crystal_osc_enable && (div % 4 == 2);
    xo_age <= hf_crystal_osc_enable ? xo_age + 1 : 0;
    hf_crystal_osc_stable <= hf_crystal_osc_enable && (xo_age >= XO_START);
    rc_age <= lf_rc_osc_enable ? rc_age + 1 : 0;
    lf_rc_osc_ready <= lf_rc_osc_enable && (rc_age >= RC_START);
    lf_rc_osc_level <= lf_rc_osc_enable && (rc_age >= RC_START) && ((rc_age / 8) % 2 == 1);
    lx_age <= lf_crystal_osc_enable ? lx_age + 1 : 0;
    lf_crystal_osc_ready <= lf_crystal_osc_enable && (lx_age >= LX_START);
    lf_crystal_osc_level <= lf_crystal_osc_enable && (lx_age >= LX_START)
                            && ((lx_age / 10) % 2 == 1);
  end
endmodule

//--- tb/clock_source_controller_test.sv
// Self-checking bench for the clock source controller top.
// Assumes the oscillator model drives all far-side inputs.
`timescale 1ns/1ps
module clock_source_controller_test import csc_pkg::*; ;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clock_en = 1'b1;
  logic [CSC_ADDR_W-1:0] reg_addr = 8'h00;
  logic [CSC_DATA_W-1:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [CSC_DATA_W-1:0] reg_rdata;
  logic cpu_clock_req = 1'b0;
  logic periph_1m_req = 1'b0;
  logic periph_16m_req = 1'b0;
  logic periph_32m_req = 1'b0;
  logic watchdog_running = 1'b0;
  logic modem_lf_req = 1'b0;
  logic system_off = 1'b0;
  logic hf_internal_osc_tick, hf_crystal_osc_tick, hf_crystal_osc_stable;
  logic hf_internal_osc_enable, hf_crystal_osc_enable, hf_power_save;
  logic high_freq_clock_en, periph_clock_1m_en, periph_clock_16m_en, periph_clock_32m_en;
  logic lf_rc_osc_level, lf_rc_osc_ready, lf_crystal_osc_level, lf_crystal_osc_ready;
  logic lf_rc_osc_enable, lf_crystal_osc_enable, low_freq_clock;
  int mismatches = 0;
  int cmp_count = 0;
  int c_cpu, c_32, c_16, c_1, run, n, i;
  logic cnt_on = 1'b0;
  logic glitch_on = 1'b0;
  logic lf_prev = 1'b0;
  logic [31:0] d;

  always #2 clock = ~clock;

  csc_top dut_u (.clock(clock), .resetn(resetn), .clock_en(clock_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cpu_clock_req(cpu_clock_req), .periph_1m_req(periph_1m_req),
    .periph_16m_req(periph_16m_req), .periph_32m_req(periph_32m_req),
    .hf_internal_osc_tick(hf_internal_osc_tick), .hf_crystal_osc_tick(hf_crystal_osc_tick),
    .hf_crystal_osc_stable(hf_crystal_osc_stable),
    .hf_internal_osc_enable(hf_internal_osc_enable),
    .hf_crystal_osc_enable(hf_crystal_osc_enable), .hf_power_save(hf_power_save),
    .high_freq_clock_en(high_freq_clock_en), .periph_clock_1m_en(periph_clock_1m_en),
    .periph_clock_16m_en(periph_clock_16m_en), .periph_clock_32m_en(periph_clock_32m_en),
    .lf_rc_osc_level(lf_rc_osc_level), .lf_rc_osc_ready(lf_rc_osc_ready),
    .lf_crystal_osc_level(lf_crystal_osc_level), .lf_crystal_osc_ready(lf_crystal_osc_ready),
    .lf_rc_osc_enable(lf_rc_osc_enable), .lf_crystal_osc_enable(lf_crystal_osc_enable),
    .low_freq_clock(low_freq_clock), .watchdog_running(watchdog_running),
    .modem_lf_req(modem_lf_req), .system_off(system_off));

  csc_osc_model osc_u (.clock(clock), .hf_internal_osc_enable(hf_internal_osc_enable),
    .hf_crystal_osc_enable(hf_crystal_osc_enable), .lf_rc_osc_enable(lf_rc_osc_enable),
    .lf_crystal_osc_enable(lf_crystal_osc_enable), .hf_internal_osc_tick(hf_internal_osc_tick),
    .hf_crystal_osc_tick(hf_crystal_osc_tick), .hf_crystal_osc_stable(hf_crystal_osc_stable),
    .lf_rc_osc_level(lf_rc_osc_level), .lf_rc_osc_ready(lf_rc_osc_ready),
    .lf_crystal_osc_level(lf_crystal_osc_level), .lf_crystal_osc_ready(lf_crystal_osc_ready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One-cycle write strobe; the gap cycle keeps strobes from colliding
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Count level changes of the low-frequency output
  task automatic lf_edges(output int cnt);
    logic p;
    cnt = 0;
    p = low_freq_clock;
    repeat (200) begin
      @(posedge clock);
      #1;
      if (low_freq_clock !== p) cnt++;
      p = low_freq_clock;
    end
  endtask

  // Window of 512 processor enables; any such window holds whole divider periods
  always @(posedge clock) begin
    if (!cnt_on) begin
      {c_cpu, c_32, c_16, c_1} <= '0;
    end else if (c_cpu < 512) begin
      c_cpu <= c_cpu + int'(high_freq_clock_en === 1'b1);
      c_32 <= c_32 + int'(periph_clock_32m_en === 1'b1);
      c_16 <= c_16 + int'(periph_clock_16m_en === 1'b1);
      c_1 <= c_1 + int'(periph_clock_1m_en === 1'b1);
    end
  end

  always @(posedge clock) begin
    if (low_freq_clock === lf_prev) begin
      run <= run + 1;
    end else begin
      if (glitch_on) check(32'(run >= 8), 32'h1);
      run <= 1;
    end
    lf_prev <= low_freq_clock;
  end

  // Hang guard, well past the expected run length
  initial begin
    #(60000 * 4);
    mismatches++;
    end_sim;
  end

  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check(hf_power_save, 1'b1);
    rd(CSC_OFF_LFSRC, d);
    check(d, CSC_ZERO);
    rd(CSC_OFF_HFSTAT, d);
    check(d, 32'h4);
    rd(8'h40, d);
    check(d, CSC_ZERO);
    rd(CSC_OFF_TASKS, d);
    check(d, CSC_ZERO);
    // Internal source for plain requests; divider ratios per requested clock
    cpu_clock_req <= 1'b1;
    periph_1m_req <= 1'b1;
    periph_16m_req <= 1'b1;
    periph_32m_req <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check(hf_internal_osc_enable, 1'b1);
    check(hf_crystal_osc_enable, 1'b0);
    for (i = 0; i < 2; i++) begin
      cnt_on <= 1'b1;
      @(posedge clock);
      for (n = 0; n < 4000 && c_cpu < 512; n++) @(posedge clock);
      #1;
      check(c_32, 256);
      check(c_16, i ? 0 : 128);
      check(c_1, 8);
      cnt_on <= 1'b0;
      periph_16m_req <= 1'b0;
      @(posedge clock);
    end
    {cpu_clock_req, periph_1m_req, periph_32m_req} <= 3'h0;
    repeat (4) @(posedge clock);
    #1;
    check(hf_internal_osc_enable, 1'b0);
    check(hf_power_save, 1'b1);
    // Crystal start and stop written together
    cpu_clock_req <= 1'b1;
    wr(CSC_OFF_TASKS, 32'h3);
    #1;
    check(hf_crystal_osc_enable, 1'b1);
    for (i = 0; i < 100; i++) begin
      rd(CSC_OFF_EVENTS, d);
      if (d[CSC_EVT_HF] === 1'b1) break;
    end
    check(d[CSC_EVT_HF], 1'b1);
    check(hf_crystal_osc_stable, 1'b1);
    rd(CSC_OFF_HFSTAT, d);
    check(d, 32'h3);
    check(hf_internal_osc_enable, 1'b0);
    rd(CSC_OFF_EVENTS, d);
    check(d[CSC_EVT_HF], 1'b1);
    wr(CSC_OFF_EVENTS, 32'h1);
    rd(CSC_OFF_EVENTS, d);
    check(d[CSC_EVT_HF], 1'b0);
    wr(CSC_OFF_TASKS, 32'h2);
    #1;
    check(hf_crystal_osc_enable, 1'b0);
    cpu_clock_req <= 1'b0;
    // Watchdog alone brings up the RC source
    watchdog_running <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check(lf_rc_osc_enable, 1'b1);
    for (i = 0; i < 100; i++) begin
      rd(CSC_OFF_LFSTAT, d);
      if (d[CSC_LFSTAT_RUN] === 1'b1) break;
    end
    check(d, 32'h2);
    rd(CSC_OFF_EVENTS, d);
    check(d[CSC_EVT_LF], 1'b1);
    glitch_on <= 1'b1;
    lf_edges(n);
    check(32'(n >= 4), 32'h1);
    glitch_on <= 1'b0;
    system_off <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check(lf_rc_osc_enable, 1'b0);
    check(low_freq_clock, 1'b0);
    system_off <= 1'b0;
    wr(CSC_OFF_EVENTS, 32'h2);
    for (i = 0; i < 100; i++) begin
      rd(CSC_OFF_LFSTAT, d);
      if (d[CSC_LFSTAT_RUN] === 1'b1) break;
    end
    glitch_on <= 1'b1;
    wr(CSC_OFF_LFSRC, 32'h1);
    wr(CSC_OFF_TASKS, 32'h4);
    #1;
    check(lf_crystal_osc_enable, 1'b1);
    rd(CSC_OFF_LFSTAT, d);
    check(d[CSC_LFSTAT_SRC], CSC_LF_SRC_RC);
    lf_edges(n);
    check(32'(n >= 4), 32'h1);
    for (i = 0; i < 400; i++) begin
      rd(CSC_OFF_LFSTAT, d);
      if (d[CSC_LFSTAT_SRC] === CSC_LF_SRC_XO) break;
    end
    check(d[CSC_LFSTAT_SRC], CSC_LF_SRC_XO);
    check(lf_crystal_osc_ready, 1'b1);
    // stop only once running; modem keeps the clock alive
    modem_lf_req <= 1'b1;
    watchdog_running <= 1'b0;
    for (i = 0; i < 100; i++) begin
      rd(CSC_OFF_LFSTAT, d);
      if (d[CSC_LFSTAT_RUN] === 1'b1) break;
    end
    wr(CSC_OFF_TASKS, 32'h8);
    lf_edges(n);
    check(32'(n >= 4), 32'h1);
    glitch_on <= 1'b0;
    modem_lf_req <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
    check({lf_rc_osc_enable, lf_crystal_osc_enable}, 2'h0);
    end_sim;
  end
endmodule
